//--- dv/tbpc_partner.sv
// Fabric-side partner: external serial loopback and flag watcher
`timescale 1ns/1ps
`default_nettype none
module tbpc_partner (
  input wire logic clk_i,
  input wire logic tx_bit_i,
  input wire logic flip_i,
  input wire logic done_i,
  input wire logic err_i,
  output logic rx_bit_o,
  output logic [7:0] err_run_o
);
  // ********************************
  // Loopback and burst length
  // ********************************
  // One flop of skew, verifier must realign by itself
  always_ff @(posedge clk_i) begin
    rx_bit_o <= tx_bit_i ^ flip_i;
  end
  // Length of current error burst after done
  always_ff @(posedge clk_i) begin
    err_run_o <= (err_i && done_i) ? err_run_o + 8'h01 : 8'h00;
  end
endmodule
`default_nettype wire

//--- dv/tbpc_top_test.sv
// Self-checking bench of the transceiver self-test block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("ERROR at %0t: got %0h expected %0h", $time, g, e); end end
module tbpc_top_test;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic tx_rst = 1'b0;
  logic rx_rst = 1'b0;
  logic width10 = 1'b1;
  logic lpbk = 1'b0;
  logic flip = 1'b0;
  logic [1:0] mode = 2'b00;
  logic [tbpc_pkg::SWING_W-1:0] swing = 3'h0;
  logic [tbpc_pkg::SWING_W-1:0] swing_o;
  logic rx_ser, tx_ser, done, err, hold;
  logic [tbpc_pkg::DATA_W-1:0] rx_data;
  logic [tbpc_pkg::DATA_W-1:0] sr = 16'h0;
  logic [9:0] sr10 = 10'h0;
  logic [7:0] err_run;
  int fails = 0;
  int checks_done = 0;
  int k;

  tbpc_top tbpc_top_i (.ref_clk_i(clk), .resetn_i(resetn),
    .tx_digital_reset_i(tx_rst), .rx_digital_reset_i(rx_rst),
    .test_mode_i(mode), .width10_i(width10), .serial_loopback_i(lpbk),
    .output_swing_setting_i(swing), .rx_serial_i(rx_ser),
    .tx_serial_o(tx_ser), .output_swing_o(swing_o),
    .rx_fabric_data_o(rx_data), .bist_done_o(done), .bist_err_o(err));
  tbpc_partner tbpc_partner_i (.clk_i(clk), .tx_bit_i(tx_ser),
    .flip_i(flip), .done_i(done), .err_i(err), .rx_bit_o(rx_ser),
    .err_run_o(err_run));

  // ********************************
  // Clock, serial capture, helpers
  // ********************************
  initial begin
    forever #4 clk = ~clk;
  end
  // Both orders kept: word stream LSB first, low-frequency MSB first
  always @(negedge clk) begin
    sr <= {tx_ser, sr[15:1]};
    sr10 <= {sr10[8:0], tx_ser};
  end

  function automatic logic [15:0] inc_word(input int i);
    logic [7:0] b;
    b = 8'(2 * i);
    return {b + 8'h01, b};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Selector instead of a reference, so free simulators take it
  task automatic wait_bit(input logic on_done, input logic v,
                          input int lim);
    int n;
    n = 0;
    while ((on_done ? done : err) !== v && n < lim) begin
      cyc(1);
      n++;
    end
    if (n == lim) begin
      fails++;
      $display("ERROR at %0t: wait timed out", $time);
    end
  endtask

  task automatic restart(input logic with_tx);
    tx_rst = with_tx;
    rx_rst = 1'b1;
    swing = 3'($urandom);
    cyc(4);
    `CHK({done, err}, 2'b00)
    `CHK(swing_o, swing)
    tx_rst = 1'b0;
    rx_rst = 1'b0;
  endtask

  task automatic end_test(input string name);
    $display("Test %s ended, checks %0d", name, checks_done);
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ********************************
  // Watchdog, about six times the run
  // ********************************
  initial begin
    cyc(40000);
    fails++;
    $display("ERROR at %0t: watchdog expired", $time);
    finish_test();
  end

  // ********************************
  // Tests
  // ********************************
  initial begin
    void'($urandom(63132));
    cyc(16);
    resetn = 1'b1;
    cyc(3);
    `CHK({done, err, tx_ser}, 3'b000)
    mode = 2'b01;
    restart(1'b1);
    k = 0;
    while (sr !== 16'h0100 && k < 80) begin
      cyc(1);
      k++;
    end
    `CHK(sr, inc_word(0))
    for (int i = 1; i < 130; i++) begin
      cyc(16);
      `CHK(sr, inc_word(i))
      if (i == 64) `CHK(done, 1'b0)
    end
    cyc(20);
    `CHK({done, err}, 2'b10)
    `CHK(rx_data, 16'h0)
    end_test("incremental");
    restart(1'b0);
    cyc(320);
    `CHK({done, err}, 2'b00)
    tx_rst = 1'b1;
    cyc(4);
    tx_rst = 1'b0;
    wait_bit(1'b0, 1'b1, 200);
    `CHK(done, 1'b1)
    hold = 1'b1;
    repeat (100) begin
      cyc(1);
      hold &= err;
    end
    `CHK(hold, 1'b1)
    end_test("incremental_error");
    mode = 2'b10;
    lpbk = 1'b1;
    restart(1'b1);
    wait_bit(1'b1, 1'b1, 400);
    cyc(200);
    `CHK({done, err}, 2'b10)
    // No run of 16 zeros exists in the stream
    `CHK(rx_data != 16'h0, 1'b1)
    lpbk = 1'b0;
    restart(1'b0);
    wait_bit(1'b1, 1'b1, 400);
    `CHK(err, 1'b0)
    repeat (3) begin
      cyc($urandom_range(10, 60));
      flip = 1'b1;
      cyc(1);
      flip = 1'b0;
      wait_bit(1'b0, 1'b1, 20);
      cyc(3);
      `CHK(err_run >= 8'h03, 1'b1)
      wait_bit(1'b0, 1'b0, 400);
      `CHK({done, err}, 2'b10)
    end
    restart(1'b0);
    end_test("prbs");
    mode = 2'b11;
    restart(1'b1);
    k = 0;
    while (sr10 !== tbpc_pkg::LF_PATTERN && k < 40) begin
      cyc(1);
      k++;
    end
    repeat (3) begin
      cyc(10);
      `CHK(sr10, 10'h3e0)
      `CHK({done, err}, 2'b00)
    end
    width10 = 1'b0;
    restart(1'b1);
    hold = 1'b1;
    repeat (40) begin
      cyc(1);
      hold &= ~(tx_ser | done | err);
    end
    `CHK(hold, 1'b1)
    end_test("low_frequency");
    // Buffer seen through the top: verifier held in reset fills it
    mode = 2'b01;
    tx_rst = 1'b1;
    rx_rst = 1'b1;
    cyc(4);
    tx_rst = 1'b0;
    cyc(320);
    `CHK({done, err}, 2'b00)
    // Full after 16 words: serial output frozen on a zero bit
    `CHK(sr, 16'h0000)
    rx_rst = 1'b0;
    k = 0;
    while (sr !== inc_word(16) && k < 60) begin
      cyc(1);
      k++;
    end
    `CHK(sr, inc_word(16))
    cyc(1700);
    `CHK(done, 1'b0)
    wait_bit(1'b1, 1'b1, 200);
    `CHK({done, err}, 2'b10)
    end_test("fifo");
    finish_test();
  end
endmodule
`default_nettype wire

//--- hw/tbpc_fifo.sv
// Synchronous FIFO between incremental generator and verifier
`timescale 1ns/1ps
`default_nettype none
module tbpc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_ni,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } tbpc_fifo_st_t;

  tbpc_fifo_st_t q, d;
  logic full, empty, push, pop;

  // ****************************************
  // Pointers and storage
  // ****************************************
  always_comb begin
    full = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
    empty = (q.wp == q.rp);
    push = in_valid_i && !full;
    pop = out_ready_i && !empty;
    d = q;
    if (push) begin
      d.mem[q.wp[AW-1:0]] = in_data_i;
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = q.mem[q.rp[AW-1:0]];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_ni);

  a_full_no_write: assert property (full && in_valid_i |=> $stable(q.wp))
    else $error("FIFO pointer moved on a write while full");
  a_empty_no_read: assert property (empty |=> $stable(q.rp))
    else $error("FIFO read pointer moved while empty");
endmodule
`default_nettype wire

//--- hw/tbpc_pkg.sv
// Package: constants, modes and state types of the transceiver self-test
package tbpc_pkg;

  // ****************************************
  // Widths and depths
  // ****************************************
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int SWING_W = 3;
  localparam logic [SWING_W-1:0] SWING_RST = 3'h0;

  // ****************************************
  // Incremental pattern
  // ****************************************
  // Two bytes per word, so 00..FF takes 128 words
  localparam int INC_WORDS = 128;
  localparam logic [7:0] INC_START = 8'h00;
  localparam logic [7:0] INC_STEP = 8'h02;
  localparam logic [3:0] INC_LAST_BIT = 4'hf;

  // ****************************************
  // Pseudo-random and low-frequency patterns
  // ****************************************
  localparam int PRBS_LEN = 7;
  localparam int PRBS_PERIOD = 127;
  localparam logic [6:0] PRBS_SEED = 7'h7f;
  localparam int ERR_MIN_CYC = 3;
  localparam logic [9:0] LF_PATTERN = 10'h3e0;
  localparam logic [3:0] LF_FIRST = 4'h9;
  localparam logic [3:0] RX_WORD_LAST = 4'hf;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_INC = 2'b01,
    MODE_PRBS = 2'b10,
    MODE_LOWF = 2'b11
  } tbpc_mode_t;

  typedef enum logic [1:0] {
    VS_ALIGN = 2'b00,
    VS_COUNT = 2'b01,
    VS_DONE = 2'b10
  } tbpc_vstate_t;

  typedef struct packed {
    logic done;
    logic err;
  } tbpc_flags_t;

  typedef struct packed {
    logic [1:0] rst_s1;
    logic [1:0] rst_s2;
    logic ser_s1;
    logic ser_s2;
    logic [DATA_W-1:0] ser_sh;
    logic [3:0] bit_cnt;
    logic [7:0] inc_cnt;
    logic tx_bit;
    logic [SWING_W-1:0] swing;
    logic inc_started;
    logic [DATA_W-1:0] inc_exp;
    logic [7:0] inc_words;
    tbpc_vstate_t vstate;
    logic [PRBS_LEN-1:0] hist;
    logic [2:0] fill;
    logic [6:0] seq_cnt;
    logic seq_err;
    logic [1:0] err_hold;
    tbpc_flags_t flags;
    logic [3:0] rx_bcnt;
    logic [DATA_W-1:0] rx_sh;
    logic [DATA_W-1:0] rx_data;
  } tbpc_state_t;

endpackage

//--- hw/tbpc_src.sv
// Serial pattern source: PRBS7 or 10-bit low-frequency pattern
`timescale 1ns/1ps
`default_nettype none
module tbpc_src (
  input wire logic clk_i,
  input wire logic rst_ni,
  input wire logic clr_i,
  input wire logic low_freq_i,
  input wire logic width10_i,
  output logic bit_o
);
  typedef struct packed {
    logic [tbpc_pkg::PRBS_LEN-1:0] lfsr;
    logic [3:0] lf_idx;
    logic out;
  } tbpc_src_st_t;

  tbpc_src_st_t q, d;
  logic fb;

  // ****************************************
  // Pattern step
  // ****************************************
  always_comb begin
    d = q;
    fb = q.lfsr[6] ^ q.lfsr[5];
    if (clr_i) begin
      d.lfsr = tbpc_pkg::PRBS_SEED;
      d.lf_idx = tbpc_pkg::LF_FIRST;
      d.out = 1'b0;
    end else if (low_freq_i) begin
      // Low-frequency pattern only at 10-bit width
      d.out = width10_i ? tbpc_pkg::LF_PATTERN[q.lf_idx] : 1'b0;
      d.lf_idx = (q.lf_idx == 4'h0) ? tbpc_pkg::LF_FIRST : q.lf_idx - 4'h1;
    end else begin
      d.lfsr = {q.lfsr[5:0], fb};
      d.out = fb;
    end
  end

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      q <= '{lfsr: tbpc_pkg::PRBS_SEED, lf_idx: tbpc_pkg::LF_FIRST, out: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign bit_o = q.out;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_ni);

  a_lowf_ten_only: assert property (
    !clr_i && low_freq_i && !width10_i |=> !bit_o)
    else $error("Low-frequency pattern produced at 8-bit width");
endmodule
`default_nettype wire

//--- hw/tbpc_top.sv
// Transceiver self-test pattern generator, loopback and verifier
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - An incremental generator and its verifier work on 16-bit words.
// - The incremental pattern counts bytes 00 to FF and is checked after a parallel loopback.
// - During the incremental test the pattern also leaves on the serial output at the selected swing.
// - Received incremental words are never shown on the fabric data output.
// - The incremental test assumes 16-bit width, 8b/10b, byte serdes, automatic alignment and byte ordering.
// - In incremental mode a data error raises the error flag and it stays high.
// - In incremental mode done rises after a full pattern cycle or on an error and stays high.
// - Transmit reset clears the generator and receive reset clears the verifier in every mode.
// - The 8 or 10 bit setting only gates the low-frequency pattern, which exists only at 10 bits.
// - The low-frequency pattern has no verifier and both flags stay low.
// - An optional serial loopback returns the pseudo-random stream to the verifier.
// - In pseudo-random mode done rises after alignment and one clean pattern cycle and holds until receive reset.
// - After done, an error raises the error flag for at least three cycles and a clean sequence clears it.
module tbpc_top (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic tx_digital_reset_i,
  input wire logic rx_digital_reset_i,
  input wire logic [1:0] test_mode_i,
  input wire logic width10_i,
  input wire logic serial_loopback_i,
  input wire logic [tbpc_pkg::SWING_W-1:0] output_swing_setting_i,
  input wire logic rx_serial_i,
  output logic tx_serial_o,
  output logic [tbpc_pkg::SWING_W-1:0] output_swing_o,
  output logic [tbpc_pkg::DATA_W-1:0] rx_fabric_data_o,
  output logic bist_done_o,
  output logic bist_err_o
);

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ****************************************
  // Declarations
  // ****************************************
  tbpc_pkg::tbpc_state_t q, d;
  tbpc_pkg::tbpc_mode_t mode;
  logic tx_rst, rx_rst, tx_clr, rx_clr;
  logic is_inc, is_prbs, is_lowf;
  logic src_bit, rbit, pred, mism, seq_end, in_ready, out_valid;
  logic push;
  logic [tbpc_pkg::DATA_W-1:0] next_word, out_word;

  assign mode = tbpc_pkg::tbpc_mode_t'(test_mode_i);
  assign is_inc = (mode == tbpc_pkg::MODE_INC);
  assign is_prbs = (mode == tbpc_pkg::MODE_PRBS);
  assign is_lowf = (mode == tbpc_pkg::MODE_LOWF);
  // Synchronised copies of the digital reset pins
  assign tx_rst = q.rst_s2[0];
  assign rx_rst = q.rst_s2[1];
  assign tx_clr = tx_rst || !is_inc;
  assign rx_clr = rx_rst || is_lowf || (mode == tbpc_pkg::MODE_OFF);

  // Both bytes carry successive counts, two per word
  assign next_word = {q.inc_cnt + 8'h01, q.inc_cnt};
  assign push = is_inc && !tx_rst && (q.bit_cnt == tbpc_pkg::INC_LAST_BIT);

  // ****************************************
  // Parallel loopback buffer
  // ****************************************
  // Stalls during receive reset so back-pressure reaches the generator
  tbpc_fifo #(
    .WIDTH(tbpc_pkg::DATA_W),
    .DEPTH(tbpc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i(ref_clk_i),
    .rst_ni(rst_n),
    .in_valid_i(push),
    .in_ready_o(in_ready),
    .in_data_i(next_word),
    .out_valid_o(out_valid),
    .out_ready_i(!rx_rst),
    .out_data_o(out_word)
  );

  // ****************************************
  // Serial pattern source
  // ****************************************
  tbpc_src u_src (
    .clk_i(ref_clk_i),
    .rst_ni(rst_n),
    .clr_i(tx_rst || !(is_prbs || is_lowf)),
    .low_freq_i(is_lowf),
    .width10_i(width10_i),
    .bit_o(src_bit)
  );

  // Loopback taps the transmitted bit before the pin
  assign rbit = serial_loopback_i ? q.tx_bit : q.ser_s2;
  assign pred = q.hist[6] ^ q.hist[5];
  assign mism = (rbit != pred);
  assign seq_end = (q.seq_cnt == 7'(tbpc_pkg::PRBS_PERIOD - 1));

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d = q;
    // Pin synchronisers
    d.rst_s1 = {rx_digital_reset_i, tx_digital_reset_i};
    d.rst_s2 = q.rst_s1;
    d.ser_s1 = rx_serial_i;
    d.ser_s2 = q.ser_s1;
    d.swing = output_swing_setting_i;

    // Transmit side
    if (tx_clr) begin
      d.bit_cnt = 4'h0;
      d.inc_cnt = tbpc_pkg::INC_START;
      d.ser_sh = '0;
    end else if (q.bit_cnt != tbpc_pkg::INC_LAST_BIT) begin
      d.bit_cnt = q.bit_cnt + 4'h1;
      d.ser_sh = {1'b0, q.ser_sh[tbpc_pkg::DATA_W-1:1]};
    end else if (in_ready) begin
      // Word boundary: load the serial copy and push the parallel one
      d.bit_cnt = 4'h0;
      d.ser_sh = next_word;
      d.inc_cnt = q.inc_cnt + tbpc_pkg::INC_STEP;
    end
    // A full buffer freezes the serial word too, so no count is skipped
    d.tx_bit = is_inc ? d.ser_sh[0] : src_bit;

    // Incremental verifier
    if (rx_clr || !is_inc) begin
      d.inc_started = 1'b0;
      d.inc_words = 8'h00;
      d.inc_exp = '0;
    end else if (out_valid) begin
      d.inc_exp = {out_word[15:8] + tbpc_pkg::INC_STEP,
                   out_word[7:0] + tbpc_pkg::INC_STEP};
      if (!q.inc_started) begin
        // First word after reset sets the phase
        d.inc_started = 1'b1;
        d.inc_words = 8'h01;
      end else if (out_word != q.inc_exp) begin
        d.flags.err = 1'b1;
        d.flags.done = 1'b1;
      end else if (q.inc_words == 8'(tbpc_pkg::INC_WORDS - 1)) begin
        d.flags.done = 1'b1;
      end else begin
        d.inc_words = q.inc_words + 8'h01;
      end
    end

    // Pseudo-random verifier, self-aligning on the history register
    if (rx_clr || !is_prbs) begin
      d.vstate = tbpc_pkg::VS_ALIGN;
      d.hist = '0;
      d.fill = 3'h0;
      d.seq_cnt = 7'h00;
      d.seq_err = 1'b0;
      d.err_hold = 2'h0;
    end else begin
      d.hist = {q.hist[5:0], rbit};
      unique case (q.vstate)
        tbpc_pkg::VS_ALIGN: begin
          d.fill = q.fill + 3'h1;
          if (q.fill == 3'(tbpc_pkg::PRBS_LEN - 1)) begin
            d.vstate = tbpc_pkg::VS_COUNT;
            d.seq_cnt = 7'h00;
          end
        end
        tbpc_pkg::VS_COUNT: begin
          if (mism) begin
            // Boundary lost: start the clean cycle again
            d.seq_cnt = 7'h00;
          end else if (seq_end) begin
            d.vstate = tbpc_pkg::VS_DONE;
            d.flags.done = 1'b1;
            d.seq_cnt = 7'h00;
          end else begin
            d.seq_cnt = q.seq_cnt + 7'h01;
          end
        end
        tbpc_pkg::VS_DONE: begin
          d.seq_cnt = seq_end ? 7'h00 : q.seq_cnt + 7'h01;
          if (q.err_hold != 2'h0) begin
            d.err_hold = q.err_hold - 2'h1;
          end
          if (seq_end) begin
            d.seq_err = 1'b0;
            if (!q.seq_err && q.err_hold == 2'h0) begin
              d.flags.err = 1'b0;
            end
          end
          // Set wins over the clean-sequence clear
          if (mism) begin
            d.flags.err = 1'b1;
            d.seq_err = 1'b1;
            d.err_hold = 2'(tbpc_pkg::ERR_MIN_CYC - 1);
          end
        end
        default: begin
          d.vstate = tbpc_pkg::VS_ALIGN;
        end
      endcase
    end

    // Fabric data: deserialised serial stream, never incremental words
    if (rx_clr || is_inc) begin
      d.rx_bcnt = 4'h0;
      d.rx_sh = '0;
      d.rx_data = '0;
    end else begin
      d.rx_bcnt = q.rx_bcnt + 4'h1;
      d.rx_sh = {rbit, q.rx_sh[tbpc_pkg::DATA_W-1:1]};
      if (q.rx_bcnt == tbpc_pkg::RX_WORD_LAST) begin
        d.rx_data = d.rx_sh;
      end
    end

    // Flags read low in receive reset and with no verifier
    if (rx_clr) begin
      d.flags = '0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.inc_cnt <= tbpc_pkg::INC_START;
      q.swing <= tbpc_pkg::SWING_RST;
      q.vstate <= tbpc_pkg::VS_ALIGN;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign tx_serial_o = q.tx_bit;
  assign output_swing_o = q.swing;
  assign rx_fabric_data_o = q.rx_data;
  assign bist_done_o = q.flags.done;
  assign bist_err_o = q.flags.err;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_inc_steady;
    is_inc && !rx_rst && $stable(test_mode_i);
  endsequence

  sequence s_err_held;
    (bist_err_o || rx_rst || !is_prbs) [*3];
  endsequence

  a_inc_err_sticky: assert property (
    s_inc_steady and bist_err_o |=> bist_err_o || rx_rst || !is_inc)
    else $error("Incremental error flag dropped without reset");
  a_inc_err_done: assert property (is_inc && bist_err_o |-> bist_done_o)
    else $error("Error flag high without done in incremental mode");
  a_flags_rst_low: assert property (
    $past(rx_clr) |-> !bist_done_o && !bist_err_o)
    else $error("Flags not low after receive reset");
  a_lowf_no_flags: assert property (
    is_lowf && $past(is_lowf) |-> !bist_done_o && !bist_err_o)
    else $error("Flags raised for low-frequency pattern");
  a_prbs_done_hold: assert property (
    is_prbs && bist_done_o && !rx_rst && $stable(test_mode_i)
      |=> bist_done_o || rx_rst || !is_prbs)
    else $error("Pseudo-random done dropped before receive reset");
  a_prbs_err_width: assert property (
    is_prbs && $rose(bist_err_o) |-> s_err_held)
    else $error("Pseudo-random error flag shorter than three cycles");
  a_inc_no_fabric: assert property (
    $past(is_inc) && is_inc |-> rx_fabric_data_o == '0)
    else $error("Incremental words reached the fabric");
  a_inc_wrap: assert property (
    !tx_clr && in_ready && push && q.inc_cnt == 8'hfe
      |=> tx_clr || q.inc_cnt == tbpc_pkg::INC_START)
    else $error("Incremental count did not wrap to zero");
endmodule
`default_nettype wire
